// File: shared/shpf_params.svh
// offsets, field positions, reset values and timing counts of the pin front end
`ifndef SHPF_PARAMS_SVH
`define SHPF_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets (7-bit serial address space)
// ----------------------------------------------------------------------------
`define SHPF_OFS_MOTION_STATUS 7'h02
`define SHPF_OFS_DELTA_X 7'h03
`define SHPF_OFS_DELTA_Y 7'h04
`define SHPF_OFS_RESOLUTION 7'h1A
`define SHPF_OFS_MOVEMENT_OUTPUT_CONTROL 7'h1D
`define SHPF_OFS_NAVIGATION_ENGINE_CONTROL 7'h60

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SHPF_BIT_MOTION_POLARITY 7
`define SHPF_BIT_ENGINE_ENABLE 0
`define SHPF_BIT_STATUS_MOTION 7
`define SHPF_BIT_STATUS_FINGER 0
`define SHPF_BIT_ADDR_WRITE 7

// ----------------------------------------------------------------------------
// reset values and resolution code limit
// ----------------------------------------------------------------------------
`define SHPF_RST_MOVEMENT_OUTPUT_CONTROL 8'h00
`define SHPF_RST_NAVIGATION_ENGINE_CONTROL 8'h00
`define SHPF_RST_RESOLUTION 3'h0
`define SHPF_CPI_CODE_MAX 3'h4

// ----------------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------------
`define SHPF_STRAP_SETTLE_CYCLES 2'h3

`endif

// File: shared/shpf_pkg.sv
// types of the host pin front end
package shpf_pkg;

  // byte position inside a serial register access
  typedef enum logic [1:0] {
    SHPF_ST_ADDR = 2'b01,
    SHPF_ST_DATA = 2'b10
  } shpf_state_t;

  // reporting resolution codes: 250, 500, 750, 1000, 1250 counts per inch
  typedef enum logic [2:0] {
    SHPF_CPI_250 = 3'h0,
    SHPF_CPI_500 = 3'h1,
    SHPF_CPI_750 = 3'h2,
    SHPF_CPI_1000 = 3'h3,
    SHPF_CPI_1250 = 3'h4
  } shpf_cpi_t;

endpackage : shpf_pkg

// File: rtl/shpf_link_shift.sv
// serial-clock side byte shifter for four-wire mode
`include "shpf_params.svh"

module shpf_link_shift
  import shpf_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic [7:0] i_tx_byte,
  output logic [7:0] o_rx_byte,
  output logic o_rx_toggle,
  output logic o_miso
);

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic miso;
  } shpf_link_state_t;

  shpf_link_state_t st_r;
  shpf_link_state_t st_nxt;

  // received byte and toggle outlive deselect, so only system reset clears them
  logic [7:0] rx_byte_r;
  logic [7:0] rx_byte_nxt;
  logic tog_r;
  logic tog_nxt;
  logic frame_rst;

  assign frame_rst = i_cs_n | i_rst;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    rx_byte_nxt = rx_byte_r;
    tog_nxt = tog_r;
    st_nxt.rx_sh = {st_r.rx_sh[6:0], i_mosi};
    st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
    // tx byte is quasi-static: main side settles it well before a byte starts
    if (st_r.bit_cnt == 3'h0) begin
      st_nxt.miso = i_tx_byte[7];
      st_nxt.tx_sh = {i_tx_byte[6:0], 1'b0};
    end else begin
      st_nxt.miso = st_r.tx_sh[7];
      st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
    end
    if (st_r.bit_cnt == 3'h7) begin
      rx_byte_nxt = {st_r.rx_sh[6:0], i_mosi};
      tog_nxt = ~tog_r;
    end
  end

  // ----------------------------------------------------------------------------
  // registers: select high ends the frame, link clock may stop afterwards
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_link_clk or posedge frame_rst) begin
    if (frame_rst) begin
      st_r.bit_cnt <= 3'h0;
      st_r.rx_sh <= 8'h00;
      st_r.tx_sh <= 8'h00;
      st_r.miso <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // toggle starts equal to the main side copy, so no false byte after reset
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_byte_r <= 8'h00;
      tog_r <= 1'b0;
    end else begin
      rx_byte_r <= rx_byte_nxt;
      tog_r <= tog_nxt;
    end
  end

  assign o_rx_byte = rx_byte_r;
  assign o_rx_toggle = tog_r;
  assign o_miso = st_r.miso;

endmodule : shpf_link_shift

// File: rtl/shpf_frontend.sv
// host pin front end: port choice, shared pins, motion and finger outputs
//
// Behaviour
// - strap low selects two-wire port, high selects four-wire port; strap is static
// - four-wire: shared pin is host data in; two-wire: address bit 0
// - four-wire: shared pin is active-low select; two-wire: address bit 1
// - data-out pin is push-pull in four-wire, open-drain in two-wire mode
// - address strap pins are pulled low in two-wire mode, only once the straps are caught
// - motion output active low by default; polarity set in register 0x1d
// - finger presence output only while engine enable at 0x60 is set
// - low level on hardware reset input resets the device
// - high level on power-down input holds the device in shutdown
// - reporting resolution selectable among 250, 500, 750, 1000, 1250 cpi
`include "shpf_params.svh"

module shpf_frontend
  import shpf_pkg::*;
#(
  parameter int DELTA_W = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  input wire logic i_mode_select_pin,
  input wire logic i_host_in_addr0_pin,
  input wire logic i_select_addr1_pin,
  input wire logic i_miso_sda_in,
  input wire logic i_hw_reset_n,
  input wire logic i_power_down_in,
  input wire logic i_motion_event,
  input wire logic i_finger_present,
  input wire logic [DELTA_W-1:0] i_delta_x,
  input wire logic [DELTA_W-1:0] i_delta_y,
  input wire logic i_twi_sda_drive_low,
  output logic o_miso_sda_out,
  output logic o_miso_sda_oe,
  output logic o_addr_pull_en,
  output logic o_spi_mode,
  output logic [1:0] o_twi_addr_low,
  output logic o_twi_sda_rx,
  output logic o_motion,
  output logic o_finger_presence_detect,
  output logic o_power_down,
  output logic o_core_reset,
  output logic [2:0] o_cpi_code
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rstn_sync;
    logic [1:0] mode_sync;
    logic [1:0] a0_sync;
    logic [1:0] a1_sync;
    logic [1:0] sda_sync;
    logic [1:0] pd_sync;
    logic [1:0] tog_sync;
    logic tog_seen;
    logic [1:0] settle_cnt;
    logic straps_done;
    logic spi_mode;
    logic [1:0] twi_addr;
    shpf_state_t fsm;
    logic [6:0] addr;
    logic wr;
    logic [7:0] tx_byte;
    logic [7:0] move_ctl;
    logic [7:0] engine_ctl;
    logic [2:0] cpi;
    logic motion_pend;
    logic motion_out;
    logic fpd_out;
    logic sda_oe;
    logic pull_en;
    logic pd_out;
    logic core_rst;
    logic sda_rx;
  } shpf_state_s_t;

  shpf_state_s_t st_r;
  shpf_state_s_t st_nxt;

  logic [7:0] rx_byte;
  logic rx_toggle;
  logic link_miso;

  // ----------------------------------------------------------------------------
  // serial clock domain
  // ----------------------------------------------------------------------------
  shpf_link_shift u_link (
    .i_link_clk (i_link_clk),
    .i_rst (i_sys_rst),
    .i_cs_n (i_select_addr1_pin),
    .i_mosi (i_host_in_addr0_pin),
    .i_tx_byte (st_r.tx_byte),
    .o_rx_byte (rx_byte),
    .o_rx_toggle (rx_toggle),
    .o_miso (link_miso)
  );

  // ----------------------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------------------
  function automatic logic [7:0] read_reg(
    input logic [6:0] a,
    input shpf_state_s_t s,
    input logic [DELTA_W-1:0] dx,
    input logic [DELTA_W-1:0] dy
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `SHPF_OFS_MOVEMENT_OUTPUT_CONTROL: v = s.move_ctl;
      `SHPF_OFS_NAVIGATION_ENGINE_CONTROL: v = s.engine_ctl;
      `SHPF_OFS_RESOLUTION: v = {5'h00, s.cpi};
      `SHPF_OFS_DELTA_X: v = dx[7:0];
      `SHPF_OFS_DELTA_Y: v = dy[7:0];
      `SHPF_OFS_MOTION_STATUS: begin
        v[`SHPF_BIT_STATUS_MOTION] = s.motion_pend;
        v[`SHPF_BIT_STATUS_FINGER] = i_finger_present;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  logic byte_evt;
  logic cs_idle;
  logic clr_motion;
  logic in_reset;

  always_comb begin
    st_nxt = st_r;
    byte_evt = 1'b0;
    cs_idle = 1'b0;
    clr_motion = 1'b0;
    in_reset = 1'b0;

    // pin synchronisers: first stage feeds only the second
    st_nxt.rstn_sync = {st_r.rstn_sync[0], i_hw_reset_n};
    st_nxt.mode_sync = {st_r.mode_sync[0], i_mode_select_pin};
    st_nxt.a0_sync = {st_r.a0_sync[0], i_host_in_addr0_pin};
    st_nxt.a1_sync = {st_r.a1_sync[0], i_select_addr1_pin};
    st_nxt.sda_sync = {st_r.sda_sync[0], i_miso_sda_in};
    st_nxt.pd_sync = {st_r.pd_sync[0], i_power_down_in};
    st_nxt.tog_sync = {st_r.tog_sync[0], rx_toggle};
    st_nxt.tog_seen = st_r.tog_sync[1];
    st_nxt.sda_rx = st_r.sda_sync[1];

    in_reset = ~st_r.rstn_sync[1];
    st_nxt.core_rst = in_reset;
    st_nxt.pd_out = st_r.pd_sync[1];

    // straps settle through the synchronisers, then are caught once
    if (!st_r.straps_done) begin
      if (st_r.settle_cnt == `SHPF_STRAP_SETTLE_CYCLES) begin
        st_nxt.straps_done = 1'b1;
        st_nxt.spi_mode = st_r.mode_sync[1];
        st_nxt.twi_addr = {st_r.a1_sync[1], st_r.a0_sync[1]};
      end else begin
        st_nxt.settle_cnt = st_r.settle_cnt + 2'h1;
      end
    end

    // weak pull-down on both strap pins only while they act as straps
    st_nxt.pull_en = st_r.straps_done & ~st_r.spi_mode;

    byte_evt = st_r.straps_done & st_r.spi_mode & (st_r.tog_sync[1] ^ st_r.tog_seen);
    cs_idle = st_r.a1_sync[1];

    // serial register access: address byte then data byte
    unique case (st_r.fsm)
      SHPF_ST_ADDR: begin
        if (byte_evt) begin
          st_nxt.addr = rx_byte[6:0];
          st_nxt.wr = rx_byte[`SHPF_BIT_ADDR_WRITE];
          st_nxt.tx_byte = read_reg(rx_byte[6:0], st_r, i_delta_x, i_delta_y);
          // reading delta y finishes the motion report
          clr_motion = ~rx_byte[`SHPF_BIT_ADDR_WRITE] &
            (rx_byte[6:0] == `SHPF_OFS_DELTA_Y);
          st_nxt.fsm = SHPF_ST_DATA;
        end
      end
      SHPF_ST_DATA: begin
        if (byte_evt) begin
          if (st_r.wr) begin
            unique case (st_r.addr)
              `SHPF_OFS_MOVEMENT_OUTPUT_CONTROL: st_nxt.move_ctl = rx_byte;
              `SHPF_OFS_NAVIGATION_ENGINE_CONTROL: st_nxt.engine_ctl = rx_byte;
              `SHPF_OFS_RESOLUTION: begin
                // codes above the last step are ignored
                if (rx_byte[2:0] <= `SHPF_CPI_CODE_MAX && rx_byte[7:3] == 5'h00) begin
                  st_nxt.cpi = rx_byte[2:0];
                end
              end
              default: st_nxt.cpi = st_r.cpi;
            endcase
          end
          st_nxt.tx_byte = 8'h00;
          st_nxt.fsm = SHPF_ST_ADDR;
        end
      end
    endcase

    // deselect aborts a half-done access
    if (cs_idle && !byte_evt) begin
      st_nxt.fsm = SHPF_ST_ADDR;
    end

    // motion pending: new event wins over the clearing read
    if (st_r.pd_sync[1]) begin
      st_nxt.motion_pend = 1'b0;
    end else if (i_motion_event) begin
      st_nxt.motion_pend = 1'b1;
    end else if (clr_motion) begin
      st_nxt.motion_pend = 1'b0;
    end

    // polarity bit clear gives an active-low motion line
    st_nxt.motion_out = st_nxt.motion_pend ^
      ~st_r.move_ctl[`SHPF_BIT_MOTION_POLARITY];

    st_nxt.fpd_out = i_finger_present & ~st_r.pd_sync[1] &
      st_r.engine_ctl[`SHPF_BIT_ENGINE_ENABLE];

    // data-out enable: push-pull while selected, else open-drain low only
    if (!st_r.straps_done) begin
      st_nxt.sda_oe = 1'b0;
    end else if (st_r.spi_mode) begin
      st_nxt.sda_oe = ~st_r.a1_sync[1];
    end else begin
      st_nxt.sda_oe = i_twi_sda_drive_low;
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r.rstn_sync <= 2'h0;
      st_r.mode_sync <= 2'h0;
      st_r.a0_sync <= 2'h0;
      st_r.a1_sync <= 2'h3;
      st_r.sda_sync <= 2'h3;
      st_r.pd_sync <= 2'h0;
      st_r.tog_sync <= 2'h0;
      st_r.tog_seen <= 1'b0;
      st_r.settle_cnt <= 2'h0;
      st_r.straps_done <= 1'b0;
      st_r.spi_mode <= 1'b0;
      st_r.twi_addr <= 2'h0;
      st_r.fsm <= SHPF_ST_ADDR;
      st_r.addr <= 7'h00;
      st_r.wr <= 1'b0;
      st_r.tx_byte <= 8'h00;
      st_r.move_ctl <= `SHPF_RST_MOVEMENT_OUTPUT_CONTROL;
      st_r.engine_ctl <= `SHPF_RST_NAVIGATION_ENGINE_CONTROL;
      st_r.cpi <= `SHPF_RST_RESOLUTION;
      st_r.motion_pend <= 1'b0;
      st_r.motion_out <= 1'b1;
      st_r.fpd_out <= 1'b0;
      st_r.sda_oe <= 1'b0;
      st_r.pull_en <= 1'b0;
      st_r.pd_out <= 1'b0;
      st_r.core_rst <= 1'b1;
      st_r.sda_rx <= 1'b1;
    end else if (in_reset) begin
      // pin reset: keep synchronisers running, restart everything else
      st_r <= '0;
      st_r.rstn_sync <= st_nxt.rstn_sync;
      st_r.mode_sync <= st_nxt.mode_sync;
      st_r.a0_sync <= st_nxt.a0_sync;
      st_r.a1_sync <= st_nxt.a1_sync;
      st_r.sda_sync <= st_nxt.sda_sync;
      st_r.pd_sync <= st_nxt.pd_sync;
      st_r.tog_sync <= st_nxt.tog_sync;
      st_r.tog_seen <= st_nxt.tog_seen;
      st_r.sda_rx <= st_nxt.sda_rx;
      st_r.fsm <= SHPF_ST_ADDR;
      st_r.move_ctl <= `SHPF_RST_MOVEMENT_OUTPUT_CONTROL;
      st_r.engine_ctl <= `SHPF_RST_NAVIGATION_ENGINE_CONTROL;
      st_r.cpi <= `SHPF_RST_RESOLUTION;
      st_r.motion_out <= 1'b1;
      st_r.core_rst <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------------------
  assign o_miso_sda_out = link_miso;
  assign o_miso_sda_oe = st_r.sda_oe;
  assign o_addr_pull_en = st_r.pull_en;
  assign o_spi_mode = st_r.spi_mode;
  assign o_twi_addr_low = st_r.twi_addr;
  assign o_twi_sda_rx = st_r.sda_rx;
  assign o_motion = st_r.motion_out;
  assign o_finger_presence_detect = st_r.fpd_out;
  assign o_power_down = st_r.pd_out;
  assign o_core_reset = st_r.core_rst;
  assign o_cpi_code = st_r.cpi;

endmodule : shpf_frontend

// File: tb/shpf_frontend_properties.sv
// concurrent checks on the ports of the host pin front end
module shpf_frontend_properties (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_mode_select_pin,
  input wire logic i_host_in_addr0_pin,
  input wire logic i_select_addr1_pin,
  input wire logic i_hw_reset_n,
  input wire logic i_power_down_in,
  input wire logic i_finger_present,
  input wire logic i_twi_sda_drive_low,
  input wire logic o_miso_sda_out,
  input wire logic o_miso_sda_oe,
  input wire logic o_addr_pull_en,
  input wire logic o_spi_mode,
  input wire logic [1:0] o_twi_addr_low,
  input wire logic o_motion,
  input wire logic o_finger_presence_detect,
  input wire logic o_power_down,
  input wire logic o_core_reset,
  input wire logic [2:0] o_cpi_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------------
  // settle counter: straps are only meaningful well after reset
  // ----------------------------------------------------------------------------
  logic [3:0] rel_cnt_r;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || o_core_reset) rel_cnt_r <= 4'h0;
    else if (rel_cnt_r != 4'hF) rel_cnt_r <= rel_cnt_r + 4'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------------
  sequence s_settled;
    rel_cnt_r == 4'hF && !o_core_reset;
  endsequence
  sequence s_pd_held;
    i_power_down_in [*4];
  endsequence
  property p_motion_rst;
    disable iff (1'b0) i_sys_rst |=> o_motion;
  endproperty
  property p_mode;
    s_settled |-> o_spi_mode == i_mode_select_pin;
  endproperty
  property p_addr;
    s_settled ##0 !o_spi_mode |-> o_twi_addr_low == {i_select_addr1_pin, i_host_in_addr0_pin};
  endproperty
  property p_pull;
    s_settled |-> o_addr_pull_en == !o_spi_mode;
  endproperty
  property p_open_drain;
    s_settled ##0 !o_spi_mode |-> !o_miso_sda_out;
  endproperty
  property p_twi_oe;
    s_settled ##0 !o_spi_mode |-> o_miso_sda_oe == $past(i_twi_sda_drive_low);
  endproperty
  property p_fpd;
    o_finger_presence_detect |-> $past(i_finger_present);
  endproperty
  property p_pd;
    s_pd_held |-> o_power_down && !o_finger_presence_detect;
  endproperty
  property p_core_rst;
    !i_hw_reset_n [*4] |-> o_core_reset;
  endproperty
  property p_cpi;
    $changed(o_cpi_code) |-> o_cpi_code <= 3'h4;
  endproperty
  a_motion_rst: assert property (p_motion_rst) else $error("motion not idle after reset");
  a_mode: assert property (p_mode) else $error("port mode differs from strap");
  a_addr: assert property (p_addr) else $error("address bits differ from straps");
  a_pull: assert property (p_pull) else $error("strap pull wrong for mode");
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  a_twi_oe: assert property (p_twi_oe) else $error("data pin enable wrong");
  a_fpd: assert property (p_fpd) else $error("finger output without finger");
  a_pd: assert property (p_pd) else $error("shutdown not applied");
  a_core_rst: assert property (p_core_rst) else $error("hardware reset ignored");
  a_cpi: assert property (p_cpi) else $error("resolution code out of range");
  c_cpi_max: cover property (o_cpi_code == 3'h4);
endmodule : shpf_frontend_properties

bind shpf_frontend shpf_frontend_properties shpf_frontend_properties_i (.i_clk, .i_sys_rst,
  .i_mode_select_pin, .i_host_in_addr0_pin, .i_select_addr1_pin, .i_hw_reset_n,
  .i_power_down_in, .i_finger_present, .i_twi_sda_drive_low, .o_miso_sda_out,
  .o_miso_sda_oe, .o_addr_pull_en, .o_spi_mode, .o_twi_addr_low, .o_motion,
  .o_finger_presence_detect, .o_power_down, .o_core_reset, .o_cpi_code);

// File: tb/shpf_host_model.sv
// host controller model: four-wire serial master
module shpf_host_model (
  output logic o_link_clk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_link_clk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // ----------------------------------------------------------------------------
  // one access: address byte, idle gap, data byte; clock stops outside bytes
  // ----------------------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [15:0] w;
    w = {a, d};
    o_cs_n = 1'b0;
    #217;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = w[i];
      #15 o_link_clk = 1'b1;
      #15 o_link_clk = 1'b0;
      if (i < 8) r[i] = i_miso;
      if (i == 8) #400;
    end
    #200 o_cs_n = 1'b1;
    // released line: no stale value left behind
    o_mosi = ~o_mosi;
    #400;
  endtask : xfer
endmodule : shpf_host_model

// File: tb/test_shpf_frontend.sv
// self-checking bench for the host pin front end
`include "shpf_params.svh"
module test_shpf_frontend;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_sys_rst, i_link_clk, i_mode_select_pin, i_hw_reset_n, i_power_down_in;
  logic i_motion_event, i_finger_present, i_twi_sda_drive_low, cs_n, mosi;
  logic [7:0] i_delta_x, i_delta_y, q;
  logic o_miso_sda_out, o_miso_sda_oe, o_addr_pull_en, o_spi_mode, o_motion;
  logic o_finger_presence_detect, o_power_down, o_core_reset, o_twi_sda_rx;
  logic [1:0] o_twi_addr_low, strap;
  logic [2:0] o_cpi_code;
  logic [31:0] lfsr;
  int errors, check_count, cyc;
  // pull-up on the data pin; straps replace host lines in two-wire mode
  wire i_miso_sda_in = o_miso_sda_oe ? o_miso_sda_out : 1'b1;
  wire i_host_in_addr0_pin = i_mode_select_pin ? mosi : strap[0];
  wire i_select_addr1_pin = i_mode_select_pin ? cs_n : strap[1];
  shpf_frontend shpf_frontend_i (.i_clk, .i_sys_rst, .i_link_clk, .i_mode_select_pin,
    .i_host_in_addr0_pin, .i_select_addr1_pin, .i_miso_sda_in, .i_hw_reset_n,
    .i_power_down_in, .i_motion_event, .i_finger_present, .i_delta_x, .i_delta_y,
    .i_twi_sda_drive_low, .o_miso_sda_out, .o_miso_sda_oe, .o_addr_pull_en, .o_spi_mode,
    .o_twi_addr_low, .o_twi_sda_rx, .o_motion, .o_finger_presence_detect, .o_power_down,
    .o_core_reset, .o_cpi_code);
  shpf_host_model shpf_host_model_i (.o_link_clk(i_link_clk), .o_cs_n(cs_n), .o_mosi(mosi),
    .i_miso(i_miso_sda_in));
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic mot(input logic pend, input logic pol);
    return pol ? pend : !pend;
  endfunction : mot
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic boot(input logic m, input logic [1:0] a);
    @(negedge i_clk);
    i_sys_rst = 1'b1;
    i_mode_select_pin = m;
    strap = a;
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (20) @(negedge i_clk);
  endtask : boot
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    shpf_host_model_i.xfer({1'b1, a}, d, q);
    @(negedge i_clk);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    shpf_host_model_i.xfer({1'b0, a}, 8'h00, q);
    @(negedge i_clk);
  endtask : rd
  task automatic pulse;
    i_motion_event = 1'b1;
    @(negedge i_clk);
    i_motion_event = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask : pulse
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  initial begin
    {i_sys_rst, i_mode_select_pin, i_hw_reset_n, strap} = 5'h0C;
    {i_power_down_in, i_motion_event, i_finger_present, i_twi_sda_drive_low} = 4'h0;
    {i_delta_x, i_delta_y} = 16'h0000;
    lfsr = 32'hE793F2F6;
    for (int a = 0; a < 4; a++) begin
      boot(1'b0, a[1:0]);
      chk(o_spi_mode, 8'h00);
      chk(o_twi_addr_low, a[7:0]);
      chk(o_addr_pull_en, 8'h01);
      repeat (8) begin
        lfsr = nxt(lfsr);
        i_twi_sda_drive_low = lfsr[0];
        @(negedge i_clk);
      end
      repeat (5) @(negedge i_clk);
      chk(o_miso_sda_oe, {7'h00, i_twi_sda_drive_low});
      chk(o_twi_sda_rx, {7'h00, ~i_twi_sda_drive_low});
    end
    boot(1'b1, 2'b11);
    chk(o_spi_mode, 8'h01);
    for (int c = 0; c < 6; c++) begin
      wr(`SHPF_OFS_RESOLUTION, c[7:0]);
      chk(o_cpi_code, (c > 4) ? 8'h04 : c[7:0]);
    end
    for (int p = 0; p < 2; p++) begin
      wr(`SHPF_OFS_MOVEMENT_OUTPUT_CONTROL, {p[0], 7'h00});
      chk(o_motion, mot(1'b0, p[0]));
      lfsr = nxt(lfsr);
      {i_delta_x, i_delta_y} = lfsr[15:0];
      pulse();
      chk(o_motion, mot(1'b1, p[0]));
      rd(`SHPF_OFS_MOTION_STATUS);
      chk(q, 8'h80);
      rd(`SHPF_OFS_DELTA_X);
      chk(q, i_delta_x);
      rd(`SHPF_OFS_DELTA_Y);
      chk(q, i_delta_y);
      chk(o_motion, mot(1'b0, p[0]));
    end
    i_finger_present = 1'b1;
    repeat (3) @(negedge i_clk);
    chk(o_finger_presence_detect, 8'h00);
    wr(`SHPF_OFS_NAVIGATION_ENGINE_CONTROL, 8'h01);
    chk(o_finger_presence_detect, 8'h01);
    i_power_down_in = 1'b1;
    repeat (5) @(negedge i_clk);
    chk(o_power_down, 8'h01);
    chk(o_finger_presence_detect, 8'h00);
    i_power_down_in = 1'b0;
    i_hw_reset_n = 1'b0;
    repeat (5) @(negedge i_clk);
    chk(o_core_reset, 8'h01);
    chk(o_cpi_code, 8'h00);
    i_hw_reset_n = 1'b1;
    repeat (20) @(negedge i_clk);
    chk(o_core_reset, 8'h00);
    chk(o_finger_presence_detect, 8'h00);
    results();
  end
endmodule : test_shpf_frontend
